/* File: shared/fmw_pkg.sv */
// constants and types for the forced media write dma command block
package fmw_pkg;
  // ***********************************************
  // command and geometry
  // ***********************************************
  localparam logic [7:0]  FMW_OPCODE      = 8'h3D;
  localparam int          FMW_SECTOR_WRDS = 256;
  localparam logic [16:0] FMW_MAX_SECTORS = 17'h1_0000;
  // ***********************************************
  // register byte offsets
  // ***********************************************
  localparam logic [5:0] FMW_OFS_COUNT   = 6'h04;
  localparam logic [5:0] FMW_OFS_SECNUM  = 6'h08;
  localparam logic [5:0] FMW_OFS_CYLLO   = 6'h0C;
  localparam logic [5:0] FMW_OFS_CYLHI   = 6'h10;
  localparam logic [5:0] FMW_OFS_DEVHEAD = 6'h14;
  localparam logic [5:0] FMW_OFS_CMDSTAT = 6'h18;
  localparam logic [5:0] FMW_OFS_ERROR   = 6'h1C;
  localparam logic [5:0] FMW_OFS_DEVCTL  = 6'h20;
  localparam logic [5:0] FMW_OFS_IRQSTAT = 6'h24;
  localparam logic [5:0] FMW_OFS_IRQMASK = 6'h28;
  // ***********************************************
  // field positions
  // ***********************************************
  localparam int FMW_ST_BUSY = 7;
  localparam int FMW_ST_RDY  = 6;
  localparam int FMW_ST_DF   = 5;
  localparam int FMW_ST_DSC  = 4;
  localparam int FMW_ST_DRQ  = 3;
  localparam int FMW_ST_COR  = 2;
  localparam int FMW_ST_ERR  = 0;
  localparam int FMW_ER_CRC  = 7;
  localparam int FMW_ER_IDN  = 4;
  localparam int FMW_ER_ABT  = 2;
  localparam int FMW_DH_LBA  = 6;
  localparam int FMW_DC_HOB  = 7;
  localparam int FMW_IRQ_DONE = 0;
  localparam int FMW_IRQ_ERR  = 1;
  // ***********************************************
  // status reset value and ending error mask
  // ***********************************************
  localparam logic [7:0] FMW_STATUS_RST = 8'h50;
  localparam logic [7:0] FMW_ERRMASK    = 8'h94;
  // ***********************************************
  // types
  // ***********************************************
  typedef enum logic [2:0] {
    FMW_IDLE  = 3'b000,
    FMW_XFER  = 3'b001,
    FMW_SWAIT = 3'b010,
    FMW_FLUSH = 3'b011,
    FMW_DONE  = 3'b100
  } fmw_state_e;
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } fmw_media_s;
endpackage

/* File: rtl/fmw_dma_ext.sv */
// forced media write dma ext command handler with axi4-lite task file
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Summary of operation
// - opcode 3Dh starts the forced write
// - media commit done before ending status
// - data moves as 16-bit words
// - words move only while request asserted
// - exactly one interrupt after final status
// - unrecoverable error stops at failing sector
// - count: current low byte, previous high
// - zero count means 65,536 sectors
// - hob clear: failing address bits 23:0
// - hob set: failing address bits 47:24
module fmw_dma_ext
  import fmw_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // axi4-lite write
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt
  output logic             irq,
  // host dma channel
  output logic             dmaRequest,
  input  wire logic        dmaAck,
  input  wire logic [15:0] dmaData,
  input  wire logic        dmaCrcError,
  // media side
  output fmw_media_s       mediaWr,
  input  wire logic        sectorDone,
  input  wire logic        sectorFail,
  output logic             flushReq,
  input  wire logic        flushDone
);
  // ***********************************************
  // declarations
  // ***********************************************
  fmw_state_e  state_q;          // command engine state
  logic [15:0] count_q;          // previous:current sector count
  logic [47:0] lbaReg_q;         // task file address bytes
  logic [7:0]  devHead_q;        // device/head
  logic [7:0]  devCtl_q;         // device control, hob select
  logic [1:0]  irqStat_q;        // sticky events
  logic [1:0]  irqMask_q;        // event enables
  logic [7:0]  status_q;         // status report
  logic [7:0]  error_q;          // error report
  logic [47:0] curLba_q;         // sector now in flight
  logic [47:0] reportLba_q;      // address handed back
  logic [16:0] remain_q;         // sectors still to write
  logic [7:0]  wordCnt_q;        // word within sector
  logic        failed_q;         // write stopped early
  logic        doneEvt;          // ending status posted
  logic        awHeld_q;         // write address captured
  logic        wHeld_q;          // write data captured
  logic [5:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        wrFire;           // register write this cycle
  logic        wrMapped;
  logic        cmdFire;          // command register write
  logic        rdFire;           // read address taken
  logic        irqRdClr;         // read of sticky events
  logic [31:0] rdMux;
  logic        rdMapped;
  logic        high_order_byte_select;
  logic        xferWord;         // dma word taken

  assign high_order_byte_select      = devCtl_q[FMW_DC_HOB];
  assign wrFire   = awHeld_q & wHeld_q & ~s_axi_bvalid;
  assign cmdFire  = wrFire & (awAddr_q == FMW_OFS_CMDSTAT) & wStrb_q[0];
  assign rdFire   = s_axi_arvalid & s_axi_arready;
  assign irqRdClr = rdFire & (s_axi_araddr == FMW_OFS_IRQSTAT);
  assign xferWord = dmaRequest & dmaAck;
  assign doneEvt  = (state_q == FMW_DONE);
  assign wrMapped = (awAddr_q <= FMW_OFS_IRQMASK)
                    & (awAddr_q[1:0] == 2'b00)
                    & (awAddr_q != 6'h00);

  // ***********************************************
  // axi4-lite write channel
  // ***********************************************
  // address and data are latched separately, so either may come first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      awAddr_q      <= 6'h00;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld_q      <= 1'b1;
        awAddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld_q      <= 1'b1;
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // answer one cycle after both halves are held
      if (wrFire) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ***********************************************
  // axi4-lite read channel
  // ***********************************************
  // task file bytes: hob picks previous (high) or current (low) half
  always_comb begin
    rdMux    = 32'h0000_0000;
    rdMapped = 1'b1;
    case (s_axi_araddr)
      FMW_OFS_COUNT:   rdMux[7:0] = high_order_byte_select ? count_q[15:8] : count_q[7:0];
      FMW_OFS_SECNUM:  rdMux[7:0] = high_order_byte_select ? lbaReg_q[31:24]
                                        : lbaReg_q[7:0];
      FMW_OFS_CYLLO:   rdMux[7:0] = high_order_byte_select ? lbaReg_q[39:32]
                                        : lbaReg_q[15:8];
      FMW_OFS_CYLHI:   rdMux[7:0] = high_order_byte_select ? lbaReg_q[47:40]
                                        : lbaReg_q[23:16];
      FMW_OFS_DEVHEAD: rdMux[7:0] = devHead_q;
      FMW_OFS_CMDSTAT: rdMux[7:0] = status_q;
      FMW_OFS_ERROR:   rdMux[7:0] = error_q;
      FMW_OFS_DEVCTL:  rdMux[7:0] = devCtl_q;
      FMW_OFS_IRQSTAT: rdMux[1:0] = irqStat_q;
      FMW_OFS_IRQMASK: rdMux[1:0] = irqMask_q;
      default:         rdMapped   = 1'b0;
    endcase
  end

  // one read at a time; data is registered with the valid
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else if (rdFire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdMux;
      s_axi_rresp   <= rdMapped ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ***********************************************
  // task file registers
  // ***********************************************
  // host writes other than control and mask are ignored while a command runs; the ending address
  // overwrites the address bytes when status is posted
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_q   <= 16'h0000;
      lbaReg_q  <= 48'h0000_0000_0000;
      devHead_q <= 8'h00;
      devCtl_q  <= 8'h00;
      irqMask_q <= 2'b00;
    end else if (doneEvt) begin
      lbaReg_q <= reportLba_q;
    end else if (wrFire & (state_q == FMW_IDLE)) begin
      case (awAddr_q)
        FMW_OFS_COUNT: begin
          if (wStrb_q[0]) count_q[7:0]  <= wData_q[7:0];
          if (wStrb_q[1]) count_q[15:8] <= wData_q[15:8];
        end
        FMW_OFS_SECNUM: begin
          if (wStrb_q[0]) lbaReg_q[7:0]   <= wData_q[7:0];
          if (wStrb_q[1]) lbaReg_q[31:24] <= wData_q[15:8];
        end
        FMW_OFS_CYLLO: begin
          if (wStrb_q[0]) lbaReg_q[15:8]  <= wData_q[7:0];
          if (wStrb_q[1]) lbaReg_q[39:32] <= wData_q[15:8];
        end
        FMW_OFS_CYLHI: begin
          if (wStrb_q[0]) lbaReg_q[23:16] <= wData_q[7:0];
          if (wStrb_q[1]) lbaReg_q[47:40] <= wData_q[15:8];
        end
        FMW_OFS_DEVHEAD: if (wStrb_q[0]) devHead_q <= wData_q[7:0];
        FMW_OFS_DEVCTL:  if (wStrb_q[0]) devCtl_q  <= wData_q[7:0];
        FMW_OFS_IRQMASK: if (wStrb_q[0]) irqMask_q <= wData_q[1:0];
        default: ;
      endcase
    end else if (wrFire) begin
      // control and mask stay writable while busy, except in the cycle that posts status
      if (awAddr_q == FMW_OFS_DEVCTL && wStrb_q[0])
        devCtl_q <= wData_q[7:0];
      if (awAddr_q == FMW_OFS_IRQMASK && wStrb_q[0])
        irqMask_q <= wData_q[1:0];
    end
  end

  // ***********************************************
  // interrupt
  // ***********************************************
  // read clears the sticky bits, but a same-cycle event still lands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStat_q <= 2'b00;
      irq       <= 1'b0;
    end else begin
      irqStat_q <= (irqRdClr ? 2'b00 : irqStat_q)
                   | {doneEvt & failed_q, doneEvt};
      irq       <= |(irqStat_q & irqMask_q);
    end
  end

  // ***********************************************
  // command engine
  // ***********************************************
  // one sector of words at a time, then wait for the media verdict;
  // every path to ending status passes through the commit flush
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= FMW_IDLE;
      status_q    <= FMW_STATUS_RST;
      error_q     <= 8'h00;
      curLba_q    <= 48'h0000_0000_0000;
      reportLba_q <= 48'h0000_0000_0000;
      remain_q    <= 17'h0_0000;
      wordCnt_q   <= 8'h00;
      failed_q    <= 1'b0;
      dmaRequest  <= 1'b0;
      mediaWr     <= '0;
      flushReq    <= 1'b0;
    end else begin
      mediaWr.valid <= 1'b0;
      case (state_q)
        FMW_IDLE: begin
          if (cmdFire) begin
            status_q[FMW_ST_BUSY] <= 1'b1;
            error_q  <= 8'h00;
            failed_q <= 1'b0;
            if (wData_q[7:0] == FMW_OPCODE &&
                devHead_q[FMW_DH_LBA]) begin
              curLba_q    <= lbaReg_q;
              reportLba_q <= lbaReg_q;
              remain_q    <= (count_q == 16'h0000) ? FMW_MAX_SECTORS
                             : {1'b0, count_q};
              wordCnt_q   <= 8'h00;
              dmaRequest  <= 1'b1;
              status_q[FMW_ST_DRQ] <= 1'b1;
              state_q     <= FMW_XFER;
            end else begin
              // unknown opcode or chs addressing: abort, but still take
              // the commit step so ending status has a single path
              error_q[FMW_ER_ABT] <= 1'b1;
              failed_q    <= 1'b1;
              reportLba_q <= lbaReg_q;
              state_q     <= FMW_FLUSH;
            end
          end
        end
        FMW_XFER: begin
          if (dmaCrcError) begin
            // link corruption: keep what was committed, stop here
            error_q[FMW_ER_CRC] <= 1'b1;
            failed_q    <= 1'b1;
            reportLba_q <= curLba_q;
            dmaRequest  <= 1'b0;
            state_q     <= FMW_FLUSH;
          end else if (xferWord) begin
            mediaWr.valid <= 1'b1;
            mediaWr.word  <= dmaData;
            wordCnt_q     <= wordCnt_q + 8'h01;
            if (wordCnt_q == 8'(FMW_SECTOR_WRDS - 1)) begin
              dmaRequest <= 1'b0;
              state_q    <= FMW_SWAIT;
            end
          end
        end
        FMW_SWAIT: begin
          if (sectorFail) begin
            error_q[FMW_ER_IDN] <= 1'b1;
            failed_q    <= 1'b1;
            reportLba_q <= curLba_q;
            state_q     <= FMW_FLUSH;
          end else if (sectorDone) begin
            reportLba_q <= curLba_q;
            remain_q    <= remain_q - 17'h0_0001;
            if (remain_q == 17'h0_0001) begin
              state_q <= FMW_FLUSH;
            end else begin
              curLba_q   <= curLba_q + 48'h0000_0000_0001;
              dmaRequest <= 1'b1;
              state_q    <= FMW_XFER;
            end
          end
        end
        FMW_FLUSH: begin
          // cache bypass: wait for the media to confirm the commit
          status_q[FMW_ST_DRQ] <= 1'b0;
          flushReq <= ~flushDone;
          if (flushDone) state_q <= FMW_DONE;
        end
        FMW_DONE: begin
          status_q <= 8'h00;
          status_q[FMW_ST_RDY] <= 1'b1;
          status_q[FMW_ST_DSC] <= 1'b1;
          status_q[FMW_ST_ERR] <= |error_q;
          error_q  <= error_q & FMW_ERRMASK;
          state_q  <= FMW_IDLE;
        end
        default: state_q <= FMW_IDLE;
      endcase
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_opcode_start;
    cmdFire && wData_q[7:0] == FMW_OPCODE && devHead_q[FMW_DH_LBA]
      |=> state_q == FMW_XFER && dmaRequest;
  endproperty
  a_opcode_start: assert property (p_opcode_start)
    else $error("opcode did not start transfer");

  property p_commit_first;
    state_q == FMW_DONE |-> $past(flushDone);
  endproperty
  a_commit_first: assert property (p_commit_first)
    else $error("status posted before media commit");

  property p_word_pass;
    xferWord && !dmaCrcError |=> mediaWr.valid
      && mediaWr.word == $past(dmaData);
  endproperty
  a_word_pass: assert property (p_word_pass)
    else $error("dma word not forwarded");

  property p_word_qualified;
    mediaWr.valid |-> $past(dmaRequest) && $past(dmaAck);
  endproperty
  a_word_qualified: assert property (p_word_qualified)
    else $error("word moved without request");

  property p_one_irq;
    doneEvt |=> !doneEvt ##1 !doneEvt && irqStat_q[FMW_IRQ_DONE];
  endproperty
  a_one_irq: assert property (p_one_irq)
    else $error("interrupt event repeated or lost");

  property p_stop_on_fail;
    state_q == FMW_SWAIT && sectorFail
      |=> !dmaRequest [*3];
  endproperty
  a_stop_on_fail: assert property (p_stop_on_fail)
    else $error("transfer resumed after failure");

  property p_zero_count;
    cmdFire && wData_q[7:0] == FMW_OPCODE && devHead_q[FMW_DH_LBA]
      && count_q == 16'h0000 |=> remain_q == FMW_MAX_SECTORS;
  endproperty
  a_zero_count: assert property (p_zero_count)
    else $error("zero count not taken as maximum");

  property p_fail_addr;
    doneEvt |=> lbaReg_q == $past(reportLba_q);
  endproperty
  a_fail_addr: assert property (p_fail_addr)
    else $error("failing address not reported");

  property p_hob_read;
    rdFire && s_axi_araddr == FMW_OFS_SECNUM && high_order_byte_select
      |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(lbaReg_q[31:24]);
  endproperty
  a_hob_read: assert property (p_hob_read)
    else $error("high address byte not returned");

  property p_end_status;
    doneEvt |=> !status_q[FMW_ST_BUSY] && !status_q[FMW_ST_DF]
      && !status_q[FMW_ST_COR] && status_q[FMW_ST_RDY]
      && status_q[FMW_ST_DSC] && (error_q & ~FMW_ERRMASK) == 8'h00
      && status_q[FMW_ST_ERR] == (error_q != 8'h00);
  endproperty
  a_end_status: assert property (p_end_status)
    else $error("ending status pattern wrong");
endmodule

/* File: verif/fmw_host_dma.sv */
// host slave dma channel model that feeds sector words to the block
`timescale 1ns/10ps
module fmw_host_dma (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // dma channel
  input  wire logic        dmaRequest,
  output logic             dmaAck,
  output logic [15:0]      dmaData,
  output logic             dmaCrcError,
  // scenario control: word index that gets a crc fault
  input  wire logic [15:0] crcAt
);
  logic [15:0] cnt_q;  // words handed over since reset
  logic [1:0]  ph_q;   // stall phase, one idle beat in four
  logic        moved;  // a word moves at this edge
  logic [15:0] nxt;    // index of the next word to offer

  assign moved = dmaRequest && dmaAck;
  assign nxt   = moved ? cnt_q + 16'h0001 : cnt_q;

  // ***********************************************
  // channel, armed from reset so no command finds it idle
  // ***********************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q       <= 16'h0000;
      ph_q        <= 2'b00;
      dmaAck      <= 1'b0;
      dmaData     <= 16'hFFFF;
      dmaCrcError <= 1'b0;
    end else begin
      cnt_q       <= nxt;
      ph_q        <= ph_q + 2'b01;
      // ack only answers a raised request; the idle beat slows us down
      dmaAck      <= dmaRequest && (ph_q != 2'b11);
      // one 16-bit word per beat; a released bus shows no stale value
      if (dmaRequest && (ph_q != 2'b11)) begin
        dmaData <= nxt ^ 16'hA5A5;
      end else begin
        dmaData <= ~dmaData;
      end
      dmaCrcError <= moved && (cnt_q == crcAt);
    end
  end
endmodule

/* File: verif/forced_media_write_dma_ext_tb.sv */
// self-checking bench for the forced media write dma command block
`timescale 1ns/10ps
module forced_media_write_dma_ext_tb
  import fmw_pkg::*;
;
  localparam logic [47:0] LBA0 = 48'hA1B2_C3D4_E5F0; // start address
  logic clk, sys_rst, irq, irqQ, dmaRequest, dmaAck, dmaCrcError;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, flushReq, flushDone, flushSeen;
  logic sectorDone, sectorFail;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] dmaData, crcAt;
  fmw_media_s  mediaWr;
  int fails, n_tests, cyc, secWords, secIdx, failAt, mediaCnt, irqRises;

  fmw_dma_ext fmw_dma_ext_inst (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq), .dmaRequest(dmaRequest),
    .dmaAck(dmaAck), .dmaData(dmaData), .dmaCrcError(dmaCrcError),
    .mediaWr(mediaWr), .sectorDone(sectorDone), .sectorFail(sectorFail),
    .flushReq(flushReq), .flushDone(flushDone));
  fmw_host_dma fmw_host_dma_inst (.clk(clk), .sys_rst(sys_rst),
    .dmaRequest(dmaRequest), .dmaAck(dmaAck), .dmaData(dmaData),
    .dmaCrcError(dmaCrcError), .crcAt(crcAt));

  // ***********************************************
  // clock and hang guard
  // ***********************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ***********************************************
  // media responder: checks words, ends sectors, commits
  // ***********************************************
  always @(posedge clk) begin
    sectorDone <= 1'b0;
    sectorFail <= 1'b0;
    flushDone  <= 1'b0;
    irqQ       <= irq;
    if (irq && !irqQ) irqRises++;
    if (flushReq) flushSeen <= 1'b1;
    // commit acknowledged a beat after the request, once
    if (flushReq && !flushDone) flushDone <= 1'b1;
    if (mediaWr.valid) begin
      check(mediaWr.word, mediaCnt[15:0] ^ 16'hA5A5);
      mediaCnt++;
      secWords++;
    end
    if (secWords == FMW_SECTOR_WRDS) begin
      secWords = 0;
      if (secIdx == failAt) sectorFail <= 1'b1;
      else sectorDone <= 1'b1;
      secIdx++;
    end
  end

  // ***********************************************
  // bus tasks and comparisons
  // ***********************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      fails++;
    end
  endtask

  // both bytes in one beat: current in 7:0, previous in 15:8
  task automatic axw(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {16'h0000, v};
    s_axi_wstrb   <= 4'h3;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [5:0] a);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // loads the task file, issues, waits for ending status
  task automatic run(input logic [15:0] cnt, input logic [7:0] op,
                     input int fAt, input logic [7:0] st, input logic [7:0] er,
                     input int words, input int rises);
    int k;
    int base;
    k = 0;
    base = mediaCnt;
    failAt = fAt;
    secIdx = 0;
    secWords = 0;
    irqRises = 0;
    flushSeen = 1'b0;
    axw(FMW_OFS_COUNT, cnt);
    axw(FMW_OFS_SECNUM, {LBA0[31:24], LBA0[7:0]});
    axw(FMW_OFS_CYLLO, {LBA0[39:32], LBA0[15:8]});
    axw(FMW_OFS_CYLHI, {LBA0[47:40], LBA0[23:16]});
    axw(FMW_OFS_DEVHEAD, 16'h0040);
    axw(FMW_OFS_CMDSTAT, {8'h00, op});
    do begin
      axr(FMW_OFS_CMDSTAT);
      k++;
    end while (d[FMW_ST_BUSY] && k < 5000);
    repeat (4) @(posedge clk);
    check(d, {24'h00_0000, st});
    axr(FMW_OFS_ERROR);
    check(d, {24'h00_0000, er});
    check(flushSeen, 1'b1);
    check(irqRises, rises);
    if (words >= 0) check(mediaCnt - base, words);
  endtask

  // reads the sticky status, expects the event bit, irq then drops
  task automatic clr(input int b);
    axr(FMW_OFS_IRQSTAT);
    check(d[b], 1'b1);
    repeat (3) @(posedge clk);
    check(irq, 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    logic [47:0] fa;
    logic [5:0]  ofs [3];
    logic [15:0] big [2];
    ofs = '{FMW_OFS_SECNUM, FMW_OFS_CYLLO, FMW_OFS_CYLHI};
    big = '{16'h0100, 16'h0000};
    fa = LBA0 + 48'h0000_0000_0001;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, sectorDone, sectorFail} = 4'b0000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_wstrb, flushDone, failAt, crcAt} = {5'h00, -32'sd1, 16'hFFFF};
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    axr(FMW_OFS_CMDSTAT);
    check(d, FMW_STATUS_RST);
    axr(6'h3C);
    check(r, 2'b10);
    // unmapped write is answered with an error, mapped one with okay
    axw(6'h3C, 16'h0000);
    check(r, 2'b10);
    axw(FMW_OFS_IRQMASK, 16'h0003);
    check(r, 2'b00);
    // plain two-sector write
    run(16'h0002, FMW_OPCODE, -1, 8'h50, 8'h00, 512, 1);
    clr(FMW_IRQ_DONE);
    // second sector fails: address of that sector reported
    run(16'h0003, FMW_OPCODE, 1, 8'h51, 8'h10, 512, 1);
    clr(FMW_IRQ_ERR);
    for (int i = 0; i < 3; i++) begin
      axr(ofs[i]);
      check(d, {24'h00_0000, fa[8*i +: 8]});
    end
    axw(FMW_OFS_DEVCTL, 16'h0080);
    for (int i = 0; i < 3; i++) begin
      axr(ofs[i]);
      check(d, {24'h00_0000, fa[24+8*i +: 8]});
    end
    axw(FMW_OFS_DEVCTL, 16'h0000);
    // long counts cut short by a fault on the third sector
    for (int i = 0; i < 2; i++) begin
      run(big[i], FMW_OPCODE, 2, 8'h51, 8'h10, 768, 1);
      clr(FMW_IRQ_ERR);
      // the fault hides the length, so the previous count byte is read
      axw(FMW_OFS_DEVCTL, 16'h0080);
      axr(FMW_OFS_COUNT);
      check(d, {24'h00_0000, big[i][15:8]});
      axw(FMW_OFS_DEVCTL, 16'h0000);
    end
    // foreign opcode under a closed mask, then the mask opens
    axw(FMW_OFS_IRQMASK, 16'h0000);
    run(16'h0001, 8'h35, -1, 8'h51, 8'h04, 0, 0);
    axw(FMW_OFS_IRQMASK, 16'h0003);
    repeat (3) @(posedge clk);
    check(irq, 1'b1);
    clr(FMW_IRQ_ERR);
    // crc fault on the link in mid-sector
    crcAt <= mediaCnt[15:0] + 16'h0064;
    run(16'h0002, FMW_OPCODE, -1, 8'h51, 8'h80, -1, 1);
    clr(FMW_IRQ_ERR);
    tally_and_finish();
  end
endmodule
